// ===== eiu_cfg.svh
// Register addresses, field positions, reset values and vector layout of the interrupt unit.
`ifndef EIU_CFG_SVH
`define EIU_CFG_SVH

`define EIU_ADDR_TCTL 8'h88
`define EIU_ADDR_ENA 8'hA8
`define EIU_ADDR_PRIO 8'hB8
`define EIU_ADDR_XCTL 8'hC0
`define EIU_RST_BYTE 8'h00

`define EIU_XC_TRIG2 0
`define EIU_XC_PEND2 1
`define EIU_XC_ENA2 2
`define EIU_XC_PRIO2 3
`define EIU_XC_TRIG3 4
`define EIU_XC_PEND3 5
`define EIU_XC_ENA3 6
`define EIU_XC_PRIO3 7

`define EIU_TC_TRIG0 0
`define EIU_TC_PEND0 1
`define EIU_TC_TRIG1 2
`define EIU_TC_PEND1 3
`define EIU_TC_MASK 8'h0F

`define EIU_ENA_ALL 7
`define EIU_VEC_BASE 8'h03
`define EIU_VEC_SHIFT 3

`endif

// ===== eiu_core_model.sv
// Processor core model that takes interrupt vectors and returns after a fixed time.
`timescale 1ns/1ns
`default_nettype none
module eiu_core_model #(
  parameter int HOLD = 40
) (
  input wire logic i_sys_clk,
  input wire logic i_go,
  input wire logic i_irq_req,
  input wire logic [7:0] i_irq_vector,
  output logic o_ack,
  output logic o_reti,
  output logic [7:0] o_vec
);
  int left = 0;
  // A taken routine runs HOLD cycles, so nested requests can be watched meanwhile.
  // Sampling on the rising edge keeps the bench's falling-edge stimulus out of a race.
  always @(posedge i_sys_clk) begin
    if (left > 0) begin
      left <= left - 1;
      o_ack <= 1'b0;
      o_reti <= (left == 1);
    end else if (i_go && i_irq_req && !o_ack && !o_reti) begin
      o_ack <= 1'b1;
      o_reti <= 1'b0;
      o_vec <= i_irq_vector;
      left <= HOLD;
    end else begin
      o_ack <= 1'b0;
      o_reti <= 1'b0;
    end
  end
endmodule : eiu_core_model
`default_nettype wire

// ===== eiu_pin_sync.sv
// Three-stage synchroniser with agreement filter and falling-edge detect for interrupt pins.
`timescale 1ns/1ns
`default_nettype none
module eiu_pin_sync #(
  parameter int W = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_pin_n,
  output logic [W-1:0] o_low,
  output logic [W-1:0] o_fall
);
  // A zero-width pin bus cannot be built, so it is refused while elaborating.
  if (W < 1) begin : g_bad_width
    $error("eiu_pin_sync: W must be at least 1");
  end

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] stable_reg;
  logic [W-1:0] fall_reg;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
    end else begin
      s1_reg <= i_pin_n;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A level only counts once the second and third stages agree.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      stable_reg <= '1;
      fall_reg <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          stable_reg[i] <= s3_reg[i];
        end
        fall_reg[i] <= stable_reg[i] & (s2_reg[i] == s3_reg[i]) & ~s3_reg[i];
      end
    end
  end

  assign o_low = ~stable_reg;
  assign o_fall = fall_reg;
endmodule : eiu_pin_sync
`default_nettype wire

// ===== eiu_pkg.sv
// Types shared by the interrupt unit.
package eiu_pkg;
  typedef logic [7:0] eiu_byte_t;
  typedef enum logic [2:0] {
    SRC_EXT0, SRC_TMR0, SRC_EXT1, SRC_TMR1, SRC_SER, SRC_TMR2, SRC_EXT2, SRC_EXT3
  } eiu_src_e;
endpackage : eiu_pkg

// ===== eiu_top.sv
// Eight-source, two-level interrupt unit with the added external interrupt control register.
`timescale 1ns/1ns
`default_nettype none
`include "eiu_cfg.svh"
// Contract
// - Added control register at 0C0H, writable per bit by set/clear.
// - Added inputs two and three act like external zero and one.
// - Priority bit set gives high level; bit 7 input three, bit 3 input two.
// - Added input taken only when enabled; bit 6 input three, bit 2 input two.
// - Trigger bit set means falling edge, clear means low level; bits 0 and 4.
// - Edge mode: flag set by detected edge, cleared when serviced.
// - Input two vectors to 33H, input three to 3BH.
// - Standard vectors 03H, 0BH, 13H, 1BH, 23H, 2BH.
// - Equal level: fixed polling order, position 0 highest, 7 lowest.
// - Six standard sources enabled by enable register bits 0 to 5.
// - External zero and one trigger type from timer control bits 0 and 2.
// - Eight sources, two levels, each source assignable to either.
// - Reset clears the added control register to zero.
// - In power-down, enabled edge-mode external inputs raise wake.
module eiu_top (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_bit_wr,
  input wire logic [7:0] i_bit_addr,
  input wire logic i_bit_val,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_pin_irq_zero_n,
  input wire logic i_pin_irq_one_n,
  input wire logic i_pin_irq_two_n,
  input wire logic i_pin_irq_three_n,
  input wire logic i_tmr0_req,
  input wire logic i_tmr1_req,
  input wire logic i_ser_req,
  input wire logic i_tmr2_req,
  input wire logic i_irq_ack,
  input wire logic i_reti,
  input wire logic i_pd,
  output logic o_irq_req,
  output logic [7:0] o_irq_vector,
  output logic [2:0] o_irq_src,
  output logic o_irq_level,
  output logic o_wake
);
  ////////////////////////////////////////////////////////////////////////////
  // Register update helper: a byte write or a bit write to a bit-addressable register.
  function automatic eiu_pkg::eiu_byte_t sfr_update(input eiu_pkg::eiu_byte_t old, input logic [7:0] addr,
      input logic wr, input logic [7:0] waddr, input logic [7:0] wdata,
      input logic bwr, input logic [7:0] baddr, input logic bval);
    eiu_pkg::eiu_byte_t v;
    v = old;
    if (wr && waddr == addr) begin
      v = wdata;
    end else if (bwr && {baddr[7:3], 3'b000} == addr) begin
      v[baddr[2:0]] = bval;
    end
    return v;
  endfunction : sfr_update

  function automatic logic [2:0] first_set(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'd0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) idx = 3'(i);
    end
    return idx;
  endfunction : first_set

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] pin_low;
  logic [3:0] pin_fall;

  eiu_pin_sync #(.W(4)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_pin_n({i_pin_irq_three_n, i_pin_irq_two_n, i_pin_irq_one_n, i_pin_irq_zero_n}),
    .o_low(pin_low),
    .o_fall(pin_fall)
  );

  eiu_pkg::eiu_byte_t timer_control_reg;
  eiu_pkg::eiu_byte_t irq_enable_reg;
  eiu_pkg::eiu_byte_t irq_priority_reg;
  eiu_pkg::eiu_byte_t added_irq_control_reg;
  eiu_pkg::eiu_byte_t tc_w;
  eiu_pkg::eiu_byte_t xc_w;
  logic hi_act_reg;
  logic lo_act_reg;

  logic [3:0] trig;
  logic [3:0] flag_w;
  logic [3:0] ack_clr;
  logic [3:0] flag_next;
  logic [7:0] req;
  logic [7:0] lvl;
  logic [7:0] hi_c;
  logic [7:0] lo_c;
  logic [7:0] cand;
  logic fire;
  logic ack_ok;

  assign tc_w = sfr_update(timer_control_reg, `EIU_ADDR_TCTL, i_sfr_wr, i_sfr_addr, i_sfr_wdata,
                           i_bit_wr, i_bit_addr, i_bit_val) & `EIU_TC_MASK;
  assign xc_w = sfr_update(added_irq_control_reg, `EIU_ADDR_XCTL, i_sfr_wr, i_sfr_addr, i_sfr_wdata,
                           i_bit_wr, i_bit_addr, i_bit_val);
  assign trig = {added_irq_control_reg[`EIU_XC_TRIG3], added_irq_control_reg[`EIU_XC_TRIG2],
                 timer_control_reg[`EIU_TC_TRIG1], timer_control_reg[`EIU_TC_TRIG0]};
  assign flag_w = {xc_w[`EIU_XC_PEND3], xc_w[`EIU_XC_PEND2], tc_w[`EIU_TC_PEND1], tc_w[`EIU_TC_PEND0]};
  assign ack_ok = i_irq_ack & o_irq_req;
  assign ack_clr = {4{ack_ok}} & {o_irq_src == 3'(eiu_pkg::SRC_EXT3), o_irq_src == 3'(eiu_pkg::SRC_EXT2),
                                   o_irq_src == 3'(eiu_pkg::SRC_EXT1), o_irq_src == 3'(eiu_pkg::SRC_EXT0)};

  // Edge mode latches and clears on service with a new edge winning; level mode tracks the pin.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (trig[i]) begin
        flag_next[i] = (flag_w[i] & ~ack_clr[i]) | pin_fall[i];
      end else begin
        flag_next[i] = pin_low[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      added_irq_control_reg <= `EIU_RST_BYTE;
      timer_control_reg <= `EIU_RST_BYTE;
      irq_enable_reg <= `EIU_RST_BYTE;
      irq_priority_reg <= `EIU_RST_BYTE;
    end else begin
      added_irq_control_reg <= xc_w;
      added_irq_control_reg[`EIU_XC_PEND2] <= flag_next[2];
      added_irq_control_reg[`EIU_XC_PEND3] <= flag_next[3];
      timer_control_reg <= tc_w;
      timer_control_reg[`EIU_TC_PEND0] <= flag_next[0];
      timer_control_reg[`EIU_TC_PEND1] <= flag_next[1];
      irq_enable_reg <= sfr_update(irq_enable_reg, `EIU_ADDR_ENA, i_sfr_wr, i_sfr_addr, i_sfr_wdata,
                                   i_bit_wr, i_bit_addr, i_bit_val);
      irq_priority_reg <= sfr_update(irq_priority_reg, `EIU_ADDR_PRIO, i_sfr_wr, i_sfr_addr, i_sfr_wdata,
                                     i_bit_wr, i_bit_addr, i_bit_val);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      unique case (i_sfr_addr)
        `EIU_ADDR_TCTL: o_sfr_rdata <= timer_control_reg;
        `EIU_ADDR_ENA: o_sfr_rdata <= irq_enable_reg;
        `EIU_ADDR_PRIO: o_sfr_rdata <= irq_priority_reg;
        `EIU_ADDR_XCTL: o_sfr_rdata <= added_irq_control_reg;
        default: o_sfr_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection.
  assign req = {8{irq_enable_reg[`EIU_ENA_ALL]}} & {
    added_irq_control_reg[`EIU_XC_PEND3] & added_irq_control_reg[`EIU_XC_ENA3],
    added_irq_control_reg[`EIU_XC_PEND2] & added_irq_control_reg[`EIU_XC_ENA2],
    irq_enable_reg[5] & i_tmr2_req,
    irq_enable_reg[4] & i_ser_req,
    irq_enable_reg[3] & i_tmr1_req,
    irq_enable_reg[2] & timer_control_reg[`EIU_TC_PEND1],
    irq_enable_reg[1] & i_tmr0_req,
    irq_enable_reg[0] & timer_control_reg[`EIU_TC_PEND0]};
  assign lvl = {added_irq_control_reg[`EIU_XC_PRIO3], added_irq_control_reg[`EIU_XC_PRIO2],
                irq_priority_reg[5:0]};
  assign hi_c = req & lvl;
  assign lo_c = req & ~lvl;
  assign cand = (|hi_c) ? hi_c : lo_c;
  // A high request only waits on a running high routine; a low one waits on either.
  assign fire = (|hi_c) ? !hi_act_reg : ((|lo_c) && !hi_act_reg && !lo_act_reg);

  // The request drops in the acknowledge cycle so a serviced source is not offered twice.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_irq_req <= 1'b0;
      o_irq_src <= 3'd0;
      o_irq_level <= 1'b0;
      o_irq_vector <= `EIU_VEC_BASE;
    end else begin
      o_irq_req <= fire & ~ack_ok;
      o_irq_src <= first_set(cand);
      o_irq_level <= |hi_c;
      o_irq_vector <= 8'(`EIU_VEC_BASE + {2'b00, first_set(cand), 3'b000});
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      hi_act_reg <= 1'b0;
      lo_act_reg <= 1'b0;
    end else begin
      if (ack_ok && o_irq_level) begin
        hi_act_reg <= 1'b1;
      end else if (i_reti && hi_act_reg) begin
        hi_act_reg <= 1'b0;
      end
      if (ack_ok && !o_irq_level) begin
        lo_act_reg <= 1'b1;
      end else if (i_reti && !hi_act_reg) begin
        lo_act_reg <= 1'b0;
      end
    end
  end

  // Only a registered hint: the clock gating and oscillator restart live outside this unit.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= i_pd & |({added_irq_control_reg[`EIU_XC_ENA3], added_irq_control_reg[`EIU_XC_ENA2],
                          irq_enable_reg[2], irq_enable_reg[0]} & trig & pin_low);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_fall3;
    pin_fall[3] && trig[3];
  endsequence

  property p_rst_clear;
    @(posedge i_sys_clk) !i_rst_n |=> added_irq_control_reg == 8'h00;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("control register not cleared by reset");

  property p_bit_write;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_bit_wr && !i_sfr_wr && i_bit_addr == 8'hC6 |=> added_irq_control_reg[6] == $past(i_bit_val);
  endproperty
  a_bit_write: assert property (p_bit_write) else $error("bit write to control register lost");

  property p_edge_set;
    @(posedge i_sys_clk) disable iff (!i_rst_n) s_fall3 |=> added_irq_control_reg[`EIU_XC_PEND3];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge did not set pending flag");

  property p_level_follow;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !trig[2] && !i_sfr_wr && !i_bit_wr |=> added_irq_control_reg[`EIU_XC_PEND2] == $past(pin_low[2]);
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("level flag does not follow pin");

  property p_vector;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      o_irq_req |-> o_irq_vector == 8'h03 + {2'b00, o_irq_src, 3'b000};
  endproperty
  a_vector: assert property (p_vector) else $error("vector does not match source");

  property p_enable3;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      o_irq_req && o_irq_src == 3'd7 |-> $past(added_irq_control_reg[`EIU_XC_ENA3]);
  endproperty
  a_enable3: assert property (p_enable3) else $error("disabled input three requested");

  property p_poll;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      o_irq_req |-> ($past(cand) & ((8'h01 << o_irq_src) - 8'h01)) == 8'h00;
  endproperty
  a_poll: assert property (p_poll) else $error("polling order violated");

  property p_level_pick;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (|hi_c) && !hi_act_reg && !ack_ok |=> o_irq_req && o_irq_level;
  endproperty
  a_level_pick: assert property (p_level_pick) else $error("low chosen over high");

  property p_nest;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      o_irq_req |-> !$past(hi_act_reg) && (!$past(lo_act_reg) || o_irq_level);
  endproperty
  a_nest: assert property (p_nest) else $error("request at blocked level");

  property p_wake;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_pd && trig[3] && pin_low[3] && added_irq_control_reg[`EIU_XC_ENA3] |=> o_wake;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missing in power-down");
endmodule : eiu_top
`default_nettype wire

// ===== eiu_top_tb.sv
// Self-checking bench for the eight-source interrupt unit.
`timescale 1ns/1ns
`default_nettype none
module eiu_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic bwr = 1'b0;
  logic [7:0] baddr = 8'h00;
  logic bval = 1'b0;
  logic [3:0] pin_n = 4'hF;
  logic [3:0] per = 4'h0;
  logic pd = 1'b0;
  logic go = 1'b0;
  logic ack, reti, req, lvl, wake;
  logic [7:0] rdata, vec, mvec;
  logic [2:0] src;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  eiu_top DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_sfr_wr(wr_s), .i_sfr_rd(rd_s), .i_sfr_addr(addr),
    .i_sfr_wdata(wdata), .i_bit_wr(bwr), .i_bit_addr(baddr), .i_bit_val(bval), .o_sfr_rdata(rdata),
    .i_pin_irq_zero_n(pin_n[0]), .i_pin_irq_one_n(pin_n[1]), .i_pin_irq_two_n(pin_n[2]),
    .i_pin_irq_three_n(pin_n[3]), .i_tmr0_req(per[0]), .i_tmr1_req(per[1]), .i_ser_req(per[2]),
    .i_tmr2_req(per[3]), .i_irq_ack(ack), .i_reti(reti), .i_pd(pd), .o_irq_req(req),
    .o_irq_vector(vec), .o_irq_src(src), .o_irq_level(lvl), .o_wake(wake));
  eiu_core_model #(.HOLD(40)) core (.i_sys_clk(clk), .i_go(go), .i_irq_req(req), .i_irq_vector(vec),
    .o_ack(ack), .o_reti(reti), .o_vec(mvec));
  initial forever #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_s = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_s = 1'b0;
  endtask : wr
  task automatic bset(input logic [7:0] a, input logic v);
    @(negedge clk);
    bwr = 1'b1;
    baddr = a;
    bval = v;
    @(negedge clk);
    bwr = 1'b0;
  endtask : bset
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd_s = 1'b1;
    addr = a;
    @(negedge clk);
    rd_s = 1'b0;
    chk(rdata, exp);
  endtask : rdchk
  // The expected vector is built from the source index: 03H plus eight per source.
  task automatic see(input logic [2:0] s, input logic l);
    for (int i = 0; i < 30 && req !== 1'b1; i++) @(negedge clk);
    chk({7'h00, req}, 8'h01);
    chk(vec, 8'h03 + {2'h0, s, 3'h0});
    chk({5'h00, src}, {5'h00, s});
    chk({7'h00, lvl}, {7'h00, l});
  endtask : see
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
    chk({7'h00, req}, 8'h00);
  endtask : idle
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdchk(8'hC0, 8'h00);
    rdchk(8'hA8, 8'h00);
    rdchk(8'h90, 8'h00);
    bset(8'hC6, 1'b1);
    bset(8'hC2, 1'b1);
    rdchk(8'hC0, 8'h44);
    bset(8'hC6, 1'b0);
    rdchk(8'hC0, 8'h04);
    $display("test regs done");
  endtask : t_regs
  task automatic t_std();
    logic [2:0] s_of[4] = '{3'h1, 3'h3, 3'h4, 3'h5};
    wr(8'hA8, 8'hBF);
    for (int k = 0; k < 4; k++) begin
      per[k] = 1'b1;
      see(s_of[k], 1'b0);
      per[k] = 1'b0;
      idle(3);
    end
    for (int k = 0; k < 2; k++) begin
      pin_n[k] = 1'b0;
      see(3'(2 * k), 1'b0);
      pin_n[k] = 1'b1;
      idle(9);
    end
    $display("test standard done");
  endtask : t_std
  task automatic t_added();
    wr(8'hA8, 8'h80);
    wr(8'hC0, 8'h44);
    for (int k = 2; k < 4; k++) begin
      pin_n[k] = 1'b0;
      see(3'(k + 4), 1'b0);
      pin_n[k] = 1'b1;
      idle(9);
    end
    wr(8'hC0, 8'h00);
    pin_n[3] = 1'b0;
    idle(10);
    pin_n[3] = 1'b1;
    $display("test added done");
  endtask : t_added
  task automatic t_order();
    wr(8'hA8, 8'hBF);
    per = 4'h9;
    see(3'h1, 1'b0);
    wr(8'hB8, 8'h20);
    repeat (2) @(negedge clk);
    see(3'h5, 1'b1);
    wr(8'hB8, 8'h00);
    per = 4'h8;
    wr(8'hC0, 8'h40);
    pin_n[3] = 1'b0;
    repeat (8) @(negedge clk);
    see(3'h5, 1'b0);
    bset(8'hC7, 1'b1);
    repeat (3) @(negedge clk);
    see(3'h7, 1'b1);
    per = 4'h0;
    pin_n[3] = 1'b1;
    wr(8'hC0, 8'h00);
    idle(9);
    $display("test order done");
  endtask : t_order
  task automatic t_edge();
    wr(8'hA8, 8'h80);
    wr(8'hC0, 8'h05);
    pin_n[2] = 1'b0;
    repeat (8) @(negedge clk);
    pin_n[2] = 1'b1;
    repeat (8) @(negedge clk);
    rdchk(8'hC0, 8'h07);
    see(3'h6, 1'b0);
    go = 1'b1;
    repeat (4) @(negedge clk);
    go = 1'b0;
    rdchk(8'hC0, 8'h05);
    chk(mvec, 8'h33);
    repeat (45) @(negedge clk);
    wr(8'h88, 8'h01);
    wr(8'hA8, 8'h81);
    pin_n[0] = 1'b0;
    repeat (8) @(negedge clk);
    pin_n[0] = 1'b1;
    repeat (8) @(negedge clk);
    see(3'h0, 1'b0);
    rdchk(8'h88, 8'h03);
    wr(8'h88, 8'h00);
    idle(3);
    $display("test edge done");
  endtask : t_edge
  task automatic t_preempt();
    wr(8'hA8, 8'h8A);
    wr(8'hC0, 8'hC0);
    per[0] = 1'b1;
    go = 1'b1;
    for (int i = 0; i < 20 && ack !== 1'b1; i++) @(negedge clk);
    go = 1'b0;
    per = 4'h2;
    idle(4);
    pin_n[3] = 1'b0;
    see(3'h7, 1'b1);
    chk(mvec, 8'h0B);
    pin_n[3] = 1'b1;
    per = 4'h0;
    repeat (50) @(negedge clk);
    $display("test preempt done");
  endtask : t_preempt
  task automatic t_wake();
    wr(8'hA8, 8'h80);
    wr(8'hC0, 8'h50);
    pd = 1'b1;
    pin_n[3] = 1'b0;
    repeat (10) @(negedge clk);
    chk({7'h00, wake}, 8'h01);
    pin_n[3] = 1'b1;
    pd = 1'b0;
    wr(8'hC0, 8'h00);
    chk({7'h00, wake}, 8'h00);
    $display("test wake done");
  endtask : t_wake
  task automatic t_reset();
    wr(8'hA8, 8'h80);
    wr(8'hC0, 8'hFF);
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    chk({7'h00, req}, 8'h00);
    rst_n = 1'b1;
    rdchk(8'hC0, 8'h00);
    rdchk(8'hA8, 8'h00);
    $display("test reset done");
  endtask : t_reset
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_regs();
    t_std();
    t_added();
    t_order();
    t_edge();
    t_preempt();
    t_wake();
    t_reset();
    end_sim();
  end
endmodule : eiu_top_tb
`default_nettype wire
